// ### ddc_pkg.sv
// Package: register map, field positions, reset values and timing for the dual converter control block
package ddc_pkg;
    // ----------------------------------------
    // Register addresses (20-bit space)
    // ----------------------------------------
    localparam logic [19:0] DDC_ADDR_PER_CLK_EN = 20'hF00F0;
    localparam logic [19:0] DDC_ADDR_VALUE_CH0 = 20'hFFF58;
    localparam logic [19:0] DDC_ADDR_VALUE_CH1 = 20'hFFF5A;
    localparam logic [19:0] DDC_ADDR_MODE_CTRL = 20'hFFF5C;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int DDC_BIT_CLK_GATE = 6;
    localparam int DDC_BIT_REF_SEL = 6;
    localparam int DDC_BIT_CONV_EN0 = 4;
    localparam int DDC_BIT_RES_SEL0 = 2;
    localparam int DDC_BIT_MODE_SEL0 = 0;
    localparam int DDC_CODE_MSB = 11;
    // ----------------------------------------
    // Reset values and masks
    // ----------------------------------------
    localparam logic [7:0] DDC_RST_PER_CLK_EN = 8'h00;
    localparam logic [7:0] DDC_RST_MODE_CTRL = 8'h00;
    localparam logic [15:0] DDC_RST_VALUE = 16'h0000;
    localparam logic [7:0] DDC_MODE_WR_MASK = 8'h7F;
    localparam logic [11:0] DDC_MASK_8BIT = 12'h0FF;
    localparam logic [11:0] DDC_MASK_12BIT = 12'hFFF;
    // ----------------------------------------
    // Reference source encodings
    // ----------------------------------------
    localparam logic [1:0] DDC_REF_SUPPLY = 2'h0;
    localparam logic [1:0] DDC_REF_EXTERNAL = 2'h1;
    localparam logic [1:0] DDC_REF_INTERNAL = 2'h2;
    localparam logic [1:0] DDC_REF_UNDEFINED = 2'h3;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int DDC_CLK_PERIOD_NS = 100;
    localparam int DDC_ENABLE_WAIT_US = 20;
    localparam int DDC_ENABLE_WAIT_CYC = (DDC_ENABLE_WAIT_US * 1000 + DDC_CLK_PERIOD_NS - 1) / DDC_CLK_PERIOD_NS;
    localparam int DDC_WAIT_W = 8;
endpackage

// ### ddc_control.sv
// Dual converter control registers, enable wait, triggers and ladder code outputs
//
// Overview of operation
// [R1] Bit 6 of peripheral enable gates converter
// [R2] Gate off: writes ignored, reads give defaults
// [R3] Gate off: whole converter held in reset
// [R4] Peripheral enable: bit/byte writes, resets zero
// [R5] Mode register bit/byte writable, bit7 reads zero
// [R6] Mode bit 6 selects positive reference
// [R7] One reference choice shared by both
// [R8] Mode bits 5,4 enable channels 1,0
// [R9] Mode bits 3,2 select 8/12-bit resolution
// [R10] Mode bits 1,0 select normal/real-time mode
// [R11] Real-time mode: timer pulses trigger conversion
// [R12] Reference source decoded from select signals
// [R13] Software starts reference before enabling conversion
// [R14] Wide value: 12-bit code, upper nibble zero
// [R15] Software avoids wide rewrite during internal-ref conversion
// [R16] Resolution picks 8 or 12 code bits
// [R17] Byte value overlays wide low byte
// [R18] Byte value accessed by byte operations
// [R19] Normal mode: value write starts conversion
// [R20] Timer ch4 triggers ch0, ch5 triggers ch1
// [R21] Conversion waits 20 us after enable
// [R22] Rewrite during settling restarts with new value
// [R23] Masked latched code presented on conversion start
`timescale 1ns/1ps
module ddc_control
    import ddc_pkg::*;
#(
    parameter int WAIT_CYCLES = DDC_ENABLE_WAIT_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Register port
    input wire logic [19:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_word,
    input wire logic [7:0] reg_bit_mask,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    // Timer triggers and reference controls
    input wire logic timer_trigger_ch4,
    input wire logic timer_trigger_ch5,
    input wire logic ref_output_select,
    input wire logic ref_generator_on,
    // Ladder interface
    output logic converter_clock_gate,
    output logic [11:0] ladder_code_ch0,
    output logic [11:0] ladder_code_ch1,
    output logic [1:0] conv_start,
    output logic [1:0] channel_active,
    output logic [1:0] ref_source
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] peripheral_clock_enable;
        logic [7:0] dac_mode_control;
        logic [11:0] value0;
        logic [11:0] value1;
        logic [DDC_WAIT_W-1:0] wait0;
        logic [DDC_WAIT_W-1:0] wait1;
        logic [1:0] ready;
        logic [11:0] code0;
        logic [11:0] code1;
        logic [1:0] start;
        logic [1:0] active;
        logic [1:0] ref_src;
        logic [15:0] rdata;
    } ddc_state_t;

    ddc_state_t st;
    ddc_state_t next_st;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Byte write with per-bit mask; a bit access sets one mask bit
    function automatic logic [7:0] ddc_merge(input logic [7:0] old, input logic [7:0] wd, input logic [7:0] m);
        ddc_merge = (old & ~m) | (wd & m);
    endfunction

    // Code masked to the channel's resolution
    function automatic logic [11:0] ddc_mask_code(input logic [11:0] v, input logic res12);
        ddc_mask_code = res12 ? (v & DDC_MASK_12BIT) : (v & DDC_MASK_8BIT);
    endfunction

    // Shared positive reference source
    function automatic logic [1:0] ddc_ref(input logic sel, input logic osel, input logic gen_on);
        if (!sel) begin
            ddc_ref = DDC_REF_SUPPLY;
        end else if (!osel && !gen_on) begin
            ddc_ref = DDC_REF_EXTERNAL;
        end else if (osel && gen_on) begin
            ddc_ref = DDC_REF_INTERNAL;
        end else begin
            ddc_ref = DDC_REF_UNDEFINED;
        end
    endfunction

    // ----------------------------------------
    // Trigger pin synchronisers
    // ----------------------------------------
    logic [1:0] trig_s1;
    logic [1:0] trig_s2;
    logic [1:0] trig_s3;
    logic [1:0] trig_rise;
    logic [1:0] trig_prev;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            trig_s1 <= 2'h0;
            trig_s2 <= 2'h0;
            trig_s3 <= 2'h0;
        end else begin
            trig_s1 <= {timer_trigger_ch5, timer_trigger_ch4};
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
        end
    end

    // Rising edge once second and third stages agree on the new level
    assign trig_rise = trig_s2 & trig_s3 & ~trig_prev;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            trig_prev <= 2'h0;
        end else begin
            trig_prev <= trig_s2 & trig_s3 | (trig_prev & (trig_s2 | trig_s3));
        end
    end

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    logic gate;
    logic sel_per;
    logic sel_mode;
    logic [1:0] sel_val;
    logic [1:0] wr_val;
    logic [1:0] en;
    logic [1:0] res;
    logic [1:0] rt;
    logic [1:0] trig;

    always_comb begin
        next_st = st;
        gate = st.peripheral_clock_enable[DDC_BIT_CLK_GATE]; // [R1]
        sel_per = reg_addr == DDC_ADDR_PER_CLK_EN;
        sel_mode = reg_addr == DDC_ADDR_MODE_CTRL;
        sel_val[0] = reg_addr == DDC_ADDR_VALUE_CH0; // [R17]
        sel_val[1] = reg_addr == DDC_ADDR_VALUE_CH1; // [R17]
        wr_val = 2'h0;
        en = st.dac_mode_control[DDC_BIT_CONV_EN0 +: 2]; // [R8]
        res = st.dac_mode_control[DDC_BIT_RES_SEL0 +: 2]; // [R9]
        rt = st.dac_mode_control[DDC_BIT_MODE_SEL0 +: 2]; // [R10]
        trig = 2'h0;
        next_st.start = 2'h0;

        // Peripheral enable, always reachable
        if (reg_wr && sel_per) begin
            next_st.peripheral_clock_enable = ddc_merge(st.peripheral_clock_enable, reg_wdata[7:0],
                reg_bit_mask); // [R4]
        end

        // Converter registers, writable only with the gate on
        if (reg_wr && gate) begin // [R2]
            if (sel_mode) begin
                next_st.dac_mode_control = ddc_merge(st.dac_mode_control, reg_wdata[7:0],
                    reg_bit_mask) & DDC_MODE_WR_MASK; // [R5]
            end
            if (sel_val[0]) begin
                wr_val[0] = 1'b1;
                next_st.value0 = reg_word ? reg_wdata[DDC_CODE_MSB:0] : {st.value0[11:8], reg_wdata[7:0]}; // [R14] [R18]
            end
            if (sel_val[1]) begin
                wr_val[1] = 1'b1;
                next_st.value1 = reg_word ? reg_wdata[DDC_CODE_MSB:0] : {st.value1[11:8], reg_wdata[7:0]}; // [R14] [R18]
            end
        end

        // Per-channel enable wait; re-enabling restarts it
        for (int i = 0; i < 2; i++) begin
            if (!en[i]) begin
                if (i == 0) begin
                    next_st.wait0 = '0;
                end else begin
                    next_st.wait1 = '0;
                end
                next_st.ready[i] = 1'b0;
                next_st.active[i] = 1'b0;
            end else if (!st.ready[i]) begin
                if (i == 0) begin
                    next_st.wait0 = st.wait0 + 1'b1;
                    next_st.ready[i] = 32'(st.wait0) >= WAIT_CYCLES - 1; // [R21]
                end else begin
                    next_st.wait1 = st.wait1 + 1'b1;
                    next_st.ready[i] = 32'(st.wait1) >= WAIT_CYCLES - 1; // [R21]
                end
            end
        end

        // Triggers: value write in normal mode, timer pulse in real-time mode
        trig[0] = rt[0] ? trig_rise[0] : wr_val[0]; // [R11] [R19] [R20]
        trig[1] = rt[1] ? trig_rise[1] : wr_val[1]; // [R11] [R19] [R20]

        // First conversion after the wait, then on each trigger; a new trigger restarts
        if (st.ready[0] && en[0] && (trig[0] || !st.active[0])) begin // [R22]
            next_st.start[0] = 1'b1;
            next_st.active[0] = 1'b1;
            next_st.code0 = ddc_mask_code(wr_val[0] ? next_st.value0 : st.value0, res[0]); // [R16] [R23]
        end
        if (st.ready[1] && en[1] && (trig[1] || !st.active[1])) begin // [R22]
            next_st.start[1] = 1'b1;
            next_st.active[1] = 1'b1;
            next_st.code1 = ddc_mask_code(wr_val[1] ? next_st.value1 : st.value1, res[1]); // [R16] [R23]
        end

        next_st.ref_src = ddc_ref(st.dac_mode_control[DDC_BIT_REF_SEL], ref_output_select,
            ref_generator_on); // [R6] [R7] [R12]

        // Read data, registered
        next_st.rdata = 16'h0000;
        if (reg_rd) begin
            if (sel_per) begin
                next_st.rdata = {8'h00, st.peripheral_clock_enable};
            end else if (sel_mode) begin
                next_st.rdata = {8'h00, st.dac_mode_control & DDC_MODE_WR_MASK}; // [R5]
            end else if (sel_val[0]) begin
                next_st.rdata = reg_word ? {4'h0, st.value0} : {8'h00, st.value0[7:0]}; // [R14] [R17]
            end else if (sel_val[1]) begin
                next_st.rdata = reg_word ? {4'h0, st.value1} : {8'h00, st.value1[7:0]}; // [R14] [R17]
            end
        end

        // Gate off holds the converter in reset; reads then return defaults
        if (!gate) begin // [R3]
            next_st.dac_mode_control = DDC_RST_MODE_CTRL;
            next_st.value0 = DDC_RST_VALUE[11:0];
            next_st.value1 = DDC_RST_VALUE[11:0];
            next_st.wait0 = '0;
            next_st.wait1 = '0;
            next_st.ready = 2'h0;
            next_st.code0 = 12'h000;
            next_st.code1 = 12'h000;
            next_st.start = 2'h0;
            next_st.active = 2'h0;
            // Registers still hold old contents in the cycle the gate drops
            if (!sel_per) begin
                next_st.rdata = 16'h0000; // [R2]
            end
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
            st.peripheral_clock_enable <= DDC_RST_PER_CLK_EN; // [R4]
            st.dac_mode_control <= DDC_RST_MODE_CTRL; // [R5]
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata = st.rdata;
    assign converter_clock_gate = st.peripheral_clock_enable[DDC_BIT_CLK_GATE]; // [R1]
    assign ladder_code_ch0 = st.code0;
    assign ladder_code_ch1 = st.code1;
    assign conv_start = st.start;
    assign channel_active = st.active;
    assign ref_source = st.ref_src;

endmodule

// ### ddc_control_sva.sv
// Concurrent checks on the converter control block ports
`timescale 1ns/1ps
module ddc_control_sva
    import ddc_pkg::*;
(
    // Clock, reset and register port
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [19:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Converter outputs
    input wire logic converter_clock_gate,
    input wire logic [11:0] ladder_code_ch0,
    input wire logic [11:0] ladder_code_ch1,
    input wire logic [1:0] conv_start,
    input wire logic [1:0] channel_active,
    input wire logic [1:0] ref_source
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence s_off;
        !converter_clock_gate [*2];
    endsequence
    sequence s_rd(a);
        reg_rd && reg_addr == a;
    endsequence
    AST_GATE_HOLD: assert property (s_off |-> ladder_code_ch0 == 12'h000 && ladder_code_ch1 == 12'h000 && channel_active == 2'h0)
        else $error("converter state live while gate off");
    AST_REF_OFF: assert property (s_off ##1 !converter_clock_gate |-> ref_source == DDC_REF_SUPPLY)
        else $error("reference not supply while gate off");
    AST_START_GATED: assert property (conv_start != 2'h0 |-> $past(converter_clock_gate))
        else $error("conversion started with gate off");
    AST_START_ACTIVE: assert property (conv_start != 2'h0 |-> (channel_active & conv_start) == conv_start)
        else $error("started channel not active");
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data without read");
    AST_RDATA_GATE: assert property (s_rd(DDC_ADDR_MODE_CTRL) ##0 !converter_clock_gate |=> reg_rdata == 16'h0000)
        else $error("mode read not default with gate off");
    AST_MODE_BIT7: assert property (s_rd(DDC_ADDR_MODE_CTRL) |=> reg_rdata[15:7] == 9'h000)
        else $error("mode upper bits not zero");
    AST_WIDE_TOP: assert property (s_rd(DDC_ADDR_VALUE_CH0) or s_rd(DDC_ADDR_VALUE_CH1) |=> reg_rdata[15:12] == 4'h0)
        else $error("value upper nibble not zero");
endmodule
bind ddc_control ddc_control_sva ddc_control_sva_inst (.mclk, .rst_b, .reg_addr, .reg_rd, .reg_rdata,
    .converter_clock_gate, .ladder_code_ch0, .ladder_code_ch1, .conv_start, .channel_active, .ref_source);

// ### test_dual_dac_control_regs.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module test_dual_dac_control_regs
    import ddc_pkg::*;
;
    localparam int W = 5;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [19:0] reg_addr = 20'h00000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic reg_word = 1'b0;
    logic [7:0] reg_bit_mask = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [1:0] tt = 2'h0;
    logic [1:0] rsel = 2'h0;
    logic [1:0] wr_start = 2'h0;
    logic [15:0] reg_rdata;
    logic converter_clock_gate;
    logic [11:0] ladder_code_ch0;
    logic [11:0] ladder_code_ch1;
    logic [1:0] conv_start;
    logic [1:0] channel_active;
    logic [1:0] ref_source;
    logic [7:0] m_per = 8'h00;
    logic [7:0] m_mode = 8'h00;
    logic [11:0] m_val [2] = '{12'h000, 12'h000};
    logic [31:0] rnd = 32'h9D71;
    int bad_count = 0;
    int n_compared = 0;
    int last_n;
    always #50 mclk = ~mclk;
    ddc_control #(.WAIT_CYCLES(W)) ddc_control_inst (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_word(reg_word), .reg_bit_mask(reg_bit_mask), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .timer_trigger_ch4(tt[0]), .timer_trigger_ch5(tt[1]), .ref_output_select(rsel[1]),
        .ref_generator_on(rsel[0]), .converter_clock_gate(converter_clock_gate), .ladder_code_ch0(ladder_code_ch0),
        .ladder_code_ch1(ladder_code_ch1), .conv_start(conv_start), .channel_active(channel_active),
        .ref_source(ref_source));
    // ----------------------------------------
    // Model and bus tasks
    // ----------------------------------------
    function automatic logic [15:0] nxt();
        rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
        return rnd[15:0];
    endfunction
    function automatic logic [15:0] mr(logic [19:0] a);
        case (a)
            DDC_ADDR_PER_CLK_EN: return {8'h00, m_per};
            DDC_ADDR_MODE_CTRL: return {8'h00, m_mode};
            DDC_ADDR_VALUE_CH0: return {4'h0, m_val[0]};
            DDC_ADDR_VALUE_CH1: return {4'h0, m_val[1]};
            default: return 16'h0000;
        endcase
    endfunction
    function automatic logic [11:0] code(int c);
        return m_mode[2 + c] ? m_val[c] : m_val[c] & 12'h0FF;
    endfunction
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [19:0] a, logic [15:0] d, logic [7:0] m, logic w);
        reg_addr <= a;
        reg_wdata <= d;
        reg_bit_mask <= m;
        reg_word <= w;
        reg_wr <= 1'b1;
        @(posedge mclk);
        #1;
        reg_wr <= 1'b0;
        // A write-triggered start pulse stands only in this cycle
        wr_start = conv_start;
        if (a == DDC_ADDR_PER_CLK_EN) begin
            m_per = (m_per & ~m) | (d[7:0] & m);
            if (!m_per[6]) begin
                m_mode = 8'h00;
                m_val = '{12'h000, 12'h000};
            end
        end else if (m_per[6] && a == DDC_ADDR_MODE_CTRL) begin
            m_mode = ((m_mode & ~m) | (d[7:0] & m)) & 8'h7F;
        end else if (m_per[6] && (a == DDC_ADDR_VALUE_CH0 || a == DDC_ADDR_VALUE_CH1)) begin
            m_val[a[1]] = w ? d[11:0] : {m_val[a[1]][11:8], d[7:0]};
        end
        @(posedge mclk);
        #1;
    endtask
    task automatic rd(logic [19:0] a);
        reg_addr <= a;
        reg_word <= 1'b1;
        reg_rd <= 1'b1;
        @(posedge mclk);
        #1;
        reg_rd <= 1'b0;
        check("reg_rdata", reg_rdata, mr(a));
        @(posedge mclk);
        #1;
    endtask
    task automatic cv(int c, int lim);
        last_n = 0;
        while (conv_start[c] !== 1'b1 && last_n < lim) begin
            @(posedge mclk);
            #1;
            last_n++;
        end
        check("conv_start", 16'(lim == 0 ? wr_start[c] : conv_start[c]), 16'h0001);
        check("ladder_code", 16'(c ? ladder_code_ch1 : ladder_code_ch0), 16'(code(c)));
    endtask
    task automatic trig(int c);
        tt[c] <= 1'b1;
        cv(c, 15);
        @(posedge mclk);
        #1;
        tt[c] <= 1'b0;
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge mclk);
        #1;
        rst_b <= 1'b1;
        @(posedge mclk);
        #1;
        wr(DDC_ADDR_MODE_CTRL, 16'h00FF, 8'hFF, 1'b0);
        wr(DDC_ADDR_VALUE_CH0, 16'h0FFF, 8'hFF, 1'b1);
        rd(DDC_ADDR_MODE_CTRL);
        rd(DDC_ADDR_VALUE_CH0);
        rd(DDC_ADDR_PER_CLK_EN);
        wr(DDC_ADDR_PER_CLK_EN, 16'h0040, 8'h40, 1'b0);
        check("gate", 16'(converter_clock_gate), 16'h0001);
        wr(DDC_ADDR_PER_CLK_EN, 16'h0081, 8'hFF, 1'b0);
        wr(DDC_ADDR_PER_CLK_EN, 16'h0040, 8'h40, 1'b0);
        rd(DDC_ADDR_PER_CLK_EN);
        wr(DDC_ADDR_MODE_CTRL, 16'h00C0, 8'hFF, 1'b0);
        rd(DDC_ADDR_MODE_CTRL);
        for (int i = 0; i < 4; i++) begin
            rsel <= 2'(i);
            repeat (4) @(posedge mclk);
            #1;
            check("ref_source", 16'(ref_source), i == 0 ? 16'h1 : i == 3 ? 16'h2 : 16'h3);
        end
        wr(DDC_ADDR_VALUE_CH0, nxt(), 8'hFF, 1'b1);
        wr(DDC_ADDR_VALUE_CH1, nxt(), 8'hFF, 1'b1);
        rd(DDC_ADDR_VALUE_CH0);
        rd(20'hFFF5E);
        wr(DDC_ADDR_MODE_CTRL, 16'h0034, 8'hFF, 1'b0);
        cv(0, 20);
        check("wait", 16'(last_n + 1 >= W), 16'h0001);
        cv(1, 2);
        check("ref_source", 16'(ref_source), 16'(DDC_REF_SUPPLY));
        wr(DDC_ADDR_VALUE_CH1, nxt(), 8'hFF, 1'b0);
        cv(1, 0);
        rd(DDC_ADDR_VALUE_CH1);
        wr(DDC_ADDR_VALUE_CH0, nxt(), 8'hFF, 1'b1);
        wr(DDC_ADDR_VALUE_CH0, nxt(), 8'hFF, 1'b1);
        cv(0, 0);
        wr(DDC_ADDR_MODE_CTRL, 16'h0037, 8'hFF, 1'b0);
        wr(DDC_ADDR_VALUE_CH0, nxt(), 8'hFF, 1'b1);
        check("conv_start", 16'(wr_start), 16'h0000);
        trig(0);
        wr(DDC_ADDR_VALUE_CH1, nxt(), 8'hFF, 1'b1);
        trig(1);
        wr(DDC_ADDR_PER_CLK_EN, 16'h0000, 8'h40, 1'b0);
        repeat (3) @(posedge mclk);
        #1;
        check("codes", 16'(ladder_code_ch0 | ladder_code_ch1), 16'h0000);
        check("active", 16'(channel_active), 16'h0000);
        wr(DDC_ADDR_PER_CLK_EN, 16'h0040, 8'h40, 1'b0);
        rd(DDC_ADDR_MODE_CTRL);
        rst_b <= 1'b0;
        @(posedge mclk);
        #1;
        rst_b <= 1'b1;
        m_per = 8'h00;
        m_mode = 8'h00;
        m_val = '{12'h000, 12'h000};
        @(posedge mclk);
        #1;
        rd(DDC_ADDR_PER_CLK_EN);
        check("active", 16'(channel_active), 16'h0000);
        complete_run();
    end
    initial begin
        #300000;
        bad_count++;
        complete_run();
    end
endmodule
